// ### inc/port_out_pkg.sv
/*
 Constants, types and helpers for the port output side: register map,
 field positions, reset values, mode coding and link word layout.
 Assumes one 32-bit AXI4-Lite register bus and a separate link clock.
*/
package port_out_pkg;
	localparam logic [31:0] ADDR_BASIC_CTRL = 32'h0000_0000;
	localparam logic [31:0] ADDR_SPECIAL_CTRL = 32'h0000_0004;
	localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
	localparam logic [31:0] ADDR_WORD_MASK = 32'h0000_00fc;
	localparam int BIT_DUPLEX = 8;
	localparam int BIT_ISOLATE = 10;
	localparam int BIT_AUTONEG = 12;
	localparam int BIT_SPEED_LOW = 13;
	localparam int BIT_CLK_DIR = 0;
	localparam logic [31:0] BASIC_CTRL_RESET = 32'h0000_3100;
	localparam logic [31:0] BASIC_CTRL_MASK = 32'h0000_3500;
	localparam logic [31:0] SPECIAL_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] SPECIAL_CTRL_MASK = 32'h0000_0001;
	localparam int ST_MODE_LSB = 0;
	localparam int ST_SPEED_POL = 2;
	localparam int ST_DUPLEX_POL = 3;
	localparam int ST_SPEED = 4;
	localparam int ST_DUPLEX = 5;
	localparam int ST_BUSY = 6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [3:0] LPI_NIBBLE = 4'h1;
	localparam logic [3:0] NIBBLE_IDLE = 4'h0;
	localparam int RMII_PHASES = 2;
	localparam int RMII_REF_MHZ = 50;
	localparam int SYNC_BITS = 6;

	typedef enum logic [1:0] {
		MODE_MII_MAC,
		MODE_MII_PHY,
		MODE_RMII_MAC,
		MODE_RMII_PHY
	} port_mode_t;

	typedef struct packed {
		logic lpi;
		logic err;
		logic [3:0] data;
	} link_word_t;

	function automatic logic mode_is_phy(input port_mode_t m);
		return (m == MODE_MII_PHY) || (m == MODE_RMII_PHY);
	endfunction : mode_is_phy

	function automatic logic mode_is_rmii(input port_mode_t m);
		return (m == MODE_RMII_MAC) || (m == MODE_RMII_PHY);
	endfunction : mode_is_rmii

	function automatic logic apply_pol(input logic pin, input logic pol);
		return pin ^ pol;
	endfunction : apply_pol

	function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
		return (old_v & ~m) | (new_v & m);
	endfunction : merge_strb
endpackage : port_out_pkg

// ### src/bit_sync.sv
/*
 Two-flop level synchroniser, any width.
 Assumes each bit is a level that changes slowly against clk.
*/
`timescale 1ns/100ps
module bit_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} sync_state_t;

	sync_state_t s_r;
	sync_state_t s_nxt;

	// First stage feeds only the second; no reset so straps pass in reset
	always_comb begin
		s_nxt.meta = d;
		s_nxt.sync = s_r.meta;
	end

	always_ff @(posedge clk) begin
		s_r <= s_nxt;
	end

	assign q = s_r.sync;
endmodule : bit_sync

// ### src/toggle_pulse.sv
/*
 Turns a toggle from another clock domain into a one-cycle pulse.
 Assumes the toggle changes at most once per few destination cycles.
*/
`timescale 1ns/100ps
module toggle_pulse (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tog,
	output logic pulse
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
	} tog_state_t;

	tog_state_t s_r;
	tog_state_t s_nxt;

	always_comb begin
		s_nxt.meta = tog;
		s_nxt.sync = s_r.meta;
		s_nxt.last = s_r.sync;
		if (!rst_n) begin
			s_nxt = '0;
		end
	end

	always_ff @(posedge clk) begin
		s_r <= s_nxt;
	end

	assign pulse = s_r.sync ^ s_r.last;
endmodule : toggle_pulse

// ### src/port_out_side.sv
/*
 Output side of a switch port media-independent interface: AXI4-Lite
 control/status registers, strap capture, speed/duplex resolution and
 the link-clock output stage for MII or RMII, MAC or PHY side.
 Assumes port_data_clock is the port output clock in MII or the 50 MHz
 reference in RMII, supplied from outside; pins are resolved by the pad.
*/
`timescale 1ns/100ps
module port_out_side (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic port_data_clock,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [3:0] tx_data,
	input wire logic tx_error,
	input wire logic tx_lpi,
	input wire logic port_mode_strap_bit2,
	input wire logic port_mode_strap_bit1,
	input wire logic speed_pol_strap,
	input wire logic duplex_pol_strap,
	input wire logic port_speed_indication_in,
	input wire logic port_duplex_indication_in,
	output logic [3:0] port_out_data_bus,
	output logic [3:0] port_out_data_bus_oe_n,
	output logic port_out_data_valid,
	output logic port_out_data_valid_oe_n,
	output logic port_out_error,
	output logic port_out_error_oe_n,
	output logic link_speed,
	output logic link_duplex,
	output logic ref_clock_drive
);
	import port_out_pkg::*;

	// Register-side state
	typedef struct packed {
		logic aw_full;
		logic [31:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] basic_ctrl;
		logic [31:0] special_ctrl;
		port_mode_t mode;
		logic speed_pol;
		logic duplex_pol;
		logic speed;
		logic duplex;
		logic busy;
		logic tx_ready;
		link_word_t word;
		logic req_tog;
	} reg_state_t;

	// Link-side state
	typedef struct packed {
		link_word_t hold;
		logic have;
		logic phase;
		logic ack_tog;
		logic [3:0] data;
		logic dv;
		logic er;
		logic [3:0] data_oe_n;
		logic dv_oe_n;
		logic er_oe_n;
	} link_state_t;

	reg_state_t r_r;
	reg_state_t r_nxt;
	link_state_t l_r;
	link_state_t l_nxt;

	logic [SYNC_BITS-1:0] pins_sync;
	logic ack_pulse;
	logic link_rst_n;
	logic [1:0] link_mode_bits;
	logic link_iso;
	logic req_pulse;
	port_mode_t link_mode;

	// Pins from outside the aclk domain
	bit_sync #(.WIDTH(SYNC_BITS)) u_pin_sync (
		.clk(aclk),
		.d({port_mode_strap_bit2, port_mode_strap_bit1, speed_pol_strap,
			duplex_pol_strap, port_speed_indication_in, port_duplex_indication_in}),
		.q(pins_sync)
	);

	toggle_pulse u_ack_sync (
		.clk(aclk),
		.rst_n(aresetn),
		.tog(l_r.ack_tog),
		.pulse(ack_pulse)
	);

	// Mode, isolate and reset are static or slow levels toward the link
	bit_sync #(.WIDTH(4)) u_link_sync (
		.clk(port_data_clock),
		.d({aresetn, r_r.mode, r_r.basic_ctrl[BIT_ISOLATE]}),
		.q({link_rst_n, link_mode_bits, link_iso})
	);

	toggle_pulse u_req_sync (
		.clk(port_data_clock),
		.rst_n(link_rst_n),
		.tog(r_r.req_tog),
		.pulse(req_pulse)
	);

	assign link_mode = port_mode_t'(link_mode_bits);

	always_comb begin
		logic aw_take;
		logic w_take;
		logic aw_have;
		logic w_have;
		logic [31:0] wa;
		logic [31:0] wd;
		logic [3:0] ws;
		logic sp_pin;
		logic du_pin;
		aw_take = s_axi_awvalid && r_r.awready;
		w_take = s_axi_wvalid && r_r.wready;
		aw_have = r_r.aw_full || aw_take;
		w_have = r_r.w_full || w_take;
		wa = r_r.aw_full ? r_r.aw_addr : s_axi_awaddr;
		wd = r_r.w_full ? r_r.w_data : s_axi_wdata;
		ws = r_r.w_full ? r_r.w_strb : s_axi_wstrb;
		r_nxt = r_r;

		if (aw_take) begin
			r_nxt.aw_full = 1'b1;
			r_nxt.aw_addr = s_axi_awaddr;
			r_nxt.awready = 1'b0;
		end
		if (w_take) begin
			r_nxt.w_full = 1'b1;
			r_nxt.w_data = s_axi_wdata;
			r_nxt.w_strb = s_axi_wstrb;
			r_nxt.wready = 1'b0;
		end
		// Write lands once both halves are in, answered next cycle
		if (aw_have && w_have && !r_r.bvalid) begin
			r_nxt.aw_full = 1'b0;
			r_nxt.w_full = 1'b0;
			r_nxt.bvalid = 1'b1;
			r_nxt.bresp = RESP_OKAY;
			r_nxt.awready = 1'b0;
			r_nxt.wready = 1'b0;
			case (wa & ADDR_WORD_MASK)
				ADDR_BASIC_CTRL: begin
					r_nxt.basic_ctrl = merge_strb(r_r.basic_ctrl, wd, ws, BASIC_CTRL_MASK);
				end
				ADDR_SPECIAL_CTRL: begin
					r_nxt.special_ctrl = merge_strb(r_r.special_ctrl, wd, ws,
						SPECIAL_CTRL_MASK);
				end
				ADDR_STATUS: begin
					r_nxt.bresp = RESP_OKAY;
				end
				default: begin
					r_nxt.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (r_r.bvalid && s_axi_bready) begin
			r_nxt.bvalid = 1'b0;
			r_nxt.awready = 1'b1;
			r_nxt.wready = 1'b1;
		end

		if (s_axi_arvalid && r_r.arready) begin
			r_nxt.arready = 1'b0;
			r_nxt.rvalid = 1'b1;
			r_nxt.rresp = RESP_OKAY;
			case (s_axi_araddr & ADDR_WORD_MASK)
				ADDR_BASIC_CTRL: begin
					r_nxt.rdata = r_r.basic_ctrl;
				end
				ADDR_SPECIAL_CTRL: begin
					r_nxt.rdata = r_r.special_ctrl;
				end
				ADDR_STATUS: begin
					r_nxt.rdata = '0;
					r_nxt.rdata[ST_MODE_LSB +: 2] = r_r.mode;
					r_nxt.rdata[ST_SPEED_POL] = r_r.speed_pol;
					r_nxt.rdata[ST_DUPLEX_POL] = r_r.duplex_pol;
					r_nxt.rdata[ST_SPEED] = r_r.speed;
					r_nxt.rdata[ST_DUPLEX] = r_r.duplex;
					r_nxt.rdata[ST_BUSY] = r_r.busy;
				end
				default: begin
					r_nxt.rdata = '0;
					r_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (r_r.rvalid && s_axi_rready) begin
			r_nxt.rvalid = 1'b0;
			r_nxt.arready = 1'b1;
		end

		// Pins are live; polarity from latched straps
		sp_pin = apply_pol(pins_sync[1], r_r.speed_pol);
		du_pin = apply_pol(pins_sync[0], r_r.duplex_pol);
		if (mode_is_phy(r_r.mode) || !r_r.basic_ctrl[BIT_AUTONEG]) begin
			r_nxt.speed = r_r.basic_ctrl[BIT_SPEED_LOW];
			r_nxt.duplex = r_r.basic_ctrl[BIT_DUPLEX];
		end else begin
			r_nxt.speed = sp_pin;
			r_nxt.duplex = du_pin;
		end

		// One word in flight; busy clears on the returned acknowledge
		if (ack_pulse) begin
			r_nxt.busy = 1'b0;
			r_nxt.tx_ready = 1'b1;
		end
		if (tx_valid && r_r.tx_ready) begin
			r_nxt.word = '{lpi: tx_lpi, err: tx_error, data: tx_data};
			r_nxt.req_tog = !r_r.req_tog;
			r_nxt.busy = 1'b1;
			r_nxt.tx_ready = 1'b0;
		end

		if (!aresetn) begin
			r_nxt = '0;
			r_nxt.awready = 1'b1;
			r_nxt.wready = 1'b1;
			r_nxt.arready = 1'b1;
			r_nxt.tx_ready = 1'b1;
			r_nxt.basic_ctrl = BASIC_CTRL_RESET;
			r_nxt.special_ctrl = SPECIAL_CTRL_RESET;
			// Straps read while drivers are off, kept after release
			r_nxt.mode = port_mode_t'(pins_sync[5:4]);
			r_nxt.speed_pol = pins_sync[3];
			r_nxt.duplex_pol = pins_sync[2];
		end
	end

	always_ff @(posedge aclk) begin
		r_r <= r_nxt;
	end

	// Link stage: one nibble per clock in MII, one dibit per clock in RMII
	always_comb begin
		logic rmii;
		logic phy;
		rmii = mode_is_rmii(link_mode);
		phy = mode_is_phy(link_mode);
		l_nxt = l_r;
		l_nxt.data = NIBBLE_IDLE;
		l_nxt.dv = 1'b0;
		l_nxt.er = 1'b0;

		if (l_r.have) begin
			if (!rmii) begin
				if (l_r.hold.lpi && !phy) begin
					l_nxt.data = LPI_NIBBLE;
					l_nxt.er = 1'b1;
				end else begin
					l_nxt.data = l_r.hold.data;
					l_nxt.dv = 1'b1;
					l_nxt.er = l_r.hold.err && !phy;
				end
				l_nxt.have = 1'b0;
				l_nxt.ack_tog = !l_r.ack_tog;
			end else begin
				// Low dibit first; upper pins stay idle
				l_nxt.data[1:0] = l_r.phase ? l_r.hold.data[3:2] : l_r.hold.data[1:0];
				l_nxt.dv = !l_r.hold.lpi;
				l_nxt.phase = !l_r.phase;
				if (l_r.phase) begin
					l_nxt.have = 1'b0;
					l_nxt.ack_tog = !l_r.ack_tog;
				end
			end
		end
		if (req_pulse) begin
			l_nxt.hold = r_r.word;
			l_nxt.have = 1'b1;
			l_nxt.phase = 1'b0;
		end

		l_nxt.data_oe_n = rmii ? 4'hc : 4'h0;
		l_nxt.dv_oe_n = 1'b0;
		l_nxt.er_oe_n = phy || rmii;
		if (phy && link_iso) begin
			l_nxt.data_oe_n = 4'hf;
			l_nxt.dv_oe_n = 1'b1;
		end

		if (!link_rst_n) begin
			l_nxt = '0;
			l_nxt.data_oe_n = 4'hf;
			l_nxt.dv_oe_n = 1'b1;
			l_nxt.er_oe_n = 1'b1;
		end
	end

	always_ff @(posedge port_data_clock) begin
		l_r <= l_nxt;
	end

	assign s_axi_awready = r_r.awready;
	assign s_axi_wready = r_r.wready;
	assign s_axi_bresp = r_r.bresp;
	assign s_axi_bvalid = r_r.bvalid;
	assign s_axi_arready = r_r.arready;
	assign s_axi_rdata = r_r.rdata;
	assign s_axi_rresp = r_r.rresp;
	assign s_axi_rvalid = r_r.rvalid;
	assign tx_ready = r_r.tx_ready;
	assign link_speed = r_r.speed;
	assign link_duplex = r_r.duplex;
	assign ref_clock_drive = r_r.special_ctrl[BIT_CLK_DIR];
	assign port_out_data_bus = l_r.data;
	assign port_out_data_bus_oe_n = l_r.data_oe_n;
	assign port_out_data_valid = l_r.dv;
	assign port_out_data_valid_oe_n = l_r.dv_oe_n;
	assign port_out_error = l_r.er;
	assign port_out_error_oe_n = l_r.er_oe_n;
endmodule : port_out_side

// ### testbench/port_out_side_monitor.sv
/* Checker on the port output side's ports, bound after the module.
 Assumes straps only move while aresetn is low, bit1 excepted. */
`timescale 1ns/100ps
module port_out_side_monitor import port_out_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic port_mode_strap_bit2,
	input wire logic port_mode_strap_bit1,
	input wire logic [3:0] port_out_data_bus_oe_n,
	input wire logic port_out_error_oe_n
);
	// Checked pin enables are static per mode, so aclk sampling is enough
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	wr_answer_a: assert property (wr_taken |=> s_axi_bvalid && !s_axi_awready)
		else $error("write not answered");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	rd_answer_a: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
		else $error("read data moved");
	// Offsets alias on the word mask, so compare the masked offset
	unmapped_read_a: assert property (rd_taken and
		((s_axi_araddr & ADDR_WORD_MASK) > ADDR_STATUS) |=>
		s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("no slave error");
	tx_slot_a: assert property (tx_valid && tx_ready |=> !tx_ready [*2] ##[1:200] tx_ready)
		else $error("word slot wrong");
	upper_idle_a: assert property (port_mode_strap_bit2 |-> &port_out_data_bus_oe_n[3:2])
		else $error("upper bits driven in RMII");
	err_off_a: assert property (port_mode_strap_bit2 || port_mode_strap_bit1 |->
		port_out_error_oe_n) else $error("error pin driven outside MII MAC");
endmodule : port_out_side_monitor

bind port_out_side port_out_side_monitor monitor (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .s_axi_rresp, .tx_valid, .tx_ready, .port_mode_strap_bit2,
	.port_mode_strap_bit1, .port_out_data_bus_oe_n, .port_out_error_oe_n);

// ### testbench/link_far_end.sv
/* Far-end PHY or MAC: listens on the output pins at the link clock.
 Assumes the pins are only read while their enables are low. */
`timescale 1ns/100ps
module link_far_end (
	input wire logic clk,
	input wire logic rmii,
	input wire logic [3:0] d,
	input wire logic dv,
	input wire logic dv_oe_n,
	input wire logic er,
	input wire logic er_oe_n,
	output logic [4:0] last,
	output logic [3:0] lpi_nib,
	output int cnt
);
	logic ph = 1'b0;
	logic [1:0] lo = 2'h0;
	initial begin
		last = 5'h0;
		lpi_nib = 4'h0;
		cnt = 0;
	end
	always @(posedge clk) begin
		if (dv && !dv_oe_n) begin
			if (!rmii) begin
				last <= {er && !er_oe_n, d};
				cnt <= cnt + 1;
			end else if (ph) begin
				last <= {1'b0, d[1:0], lo};
				cnt <= cnt + 1;
			end
			lo <= d[1:0];
			ph <= !ph && rmii;
		end else begin
			ph <= 1'b0;
			if (er && !er_oe_n) lpi_nib <= d;
		end
	end
endmodule : link_far_end

// ### testbench/port_out_side_bench.sv
/* Self-checking bench for port_out_side across all four strap modes.
 Assumes the far end only listens; the bench drives speed and duplex pins. */
`timescale 1ns/100ps
module port_out_side_bench;
	import port_out_pkg::*;
	logic aclk = 1'b0;
	logic port_data_clock = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tx_valid = 1'b0;
	logic [3:0] s_axi_wstrb = 4'hf, tx_data = 4'h0;
	logic tx_error = 1'b0, tx_lpi = 1'b0, port_mode_strap_bit2 = 1'b0;
	logic port_mode_strap_bit1 = 1'b0, speed_pol_strap = 1'b0, duplex_pol_strap = 1'b0;
	logic port_speed_indication_in = 1'b1, port_duplex_indication_in = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_ready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [3:0] port_out_data_bus, port_out_data_bus_oe_n, idle_nib;
	logic port_out_data_valid, port_out_data_valid_oe_n, port_out_error, port_out_error_oe_n;
	logic link_speed, link_duplex, ref_clock_drive;
	logic [4:0] seen;
	int seen_cnt;
	int mismatches = 0;
	int checked = 0;
	port_out_side uut (.aclk, .aresetn, .port_data_clock, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.tx_valid, .tx_ready, .tx_data, .tx_error, .tx_lpi, .port_mode_strap_bit2,
		.port_mode_strap_bit1, .speed_pol_strap, .duplex_pol_strap, .port_speed_indication_in,
		.port_duplex_indication_in, .port_out_data_bus, .port_out_data_bus_oe_n,
		.port_out_data_valid, .port_out_data_valid_oe_n, .port_out_error,
		.port_out_error_oe_n, .link_speed, .link_duplex, .ref_clock_drive);
	link_far_end far (.clk(port_data_clock), .rmii(port_mode_strap_bit2),
		.d(port_out_data_bus), .dv(port_out_data_valid), .dv_oe_n(port_out_data_valid_oe_n),
		.er(port_out_error), .er_oe_n(port_out_error_oe_n), .last(seen), .lpi_nib(idle_nib),
		.cnt(seen_cnt));
	initial forever #10 aclk = ~aclk;
	initial begin
		#7;
		forever #40 port_data_clock = ~port_data_clock;
	end
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: got %h, expected %h", $time, g, e);
		end
	endtask : chk
	task automatic tick(inout int n);
		@(posedge aclk);
		n++;
		if (n > 300) begin
			mismatches++;
			conclude();
		end
	endtask : tick
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic aw, w;
		n = 0;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			tick(n);
			if (s_axi_awready) aw = 1'b0;
			if (s_axi_wready) w = 1'b0;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end while (aw || w);
		// Late acceptance lets the answer hold check see a waiting response
		tick(n);
		s_axi_bready <= 1'b1;
		do tick(n); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask : wr
	task automatic rd(input logic [31:0] a, output logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do tick(n); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		tick(n);
		s_axi_rready <= 1'b1;
		do tick(n); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask : rd
	task automatic send(input logic [3:0] d, input logic er, input logic lpi);
		int n;
		n = 0;
		tx_data <= d;
		tx_error <= er;
		tx_lpi <= lpi;
		tx_valid <= 1'b1;
		do tick(n); while (!tx_ready);
		tx_valid <= 1'b0;
		do tick(n); while (!tx_ready);
		// Far end counts one link cycle after the acknowledge leaves
		repeat (8) @(posedge aclk);
	endtask : send
	function automatic logic [1:0] exp_link(input logic phy, input logic [31:0] ctl);
		if (phy || !ctl[BIT_AUTONEG]) return {ctl[BIT_SPEED_LOW], ctl[BIT_DUPLEX]};
		return {port_speed_indication_in ^ speed_pol_strap,
			port_duplex_indication_in ^ duplex_pol_strap};
	endfunction : exp_link
	initial begin
		logic [31:0] v, ctl;
		logic [3:0] d;
		void'($urandom(77));
		for (int m = 0; m < 4; m++) begin
			{port_mode_strap_bit2, port_mode_strap_bit1} <= 2'(m);
			speed_pol_strap <= 1'($urandom);
			duplex_pol_strap <= 1'($urandom);
			aresetn <= 1'b0;
			// Later resets also span seven link edges
			repeat ((m == 0) ? 12 : 30) @(posedge aclk);
			aresetn <= 1'b1;
			@(posedge aclk);
			rd(ADDR_STATUS, v, RESP_OKAY);
			chk(v & 32'hf, {28'h0, duplex_pol_strap, speed_pol_strap, 2'(m)});
			rd(ADDR_BASIC_CTRL, v, RESP_OKAY);
			chk(v, BASIC_CTRL_RESET);
			chk({31'h0, ref_clock_drive}, 32'h0);
			rd(32'h0000_0010, v, RESP_SLVERR);
			for (int k = 0; k < 8; k++) begin
				d = (k == 0) ? 4'hf : 4'($urandom);
				v = 32'(seen_cnt) + 32'h1;
				send(d, k[0], 1'b0);
				chk(32'(seen_cnt), v);
				chk({27'h0, seen}, {27'h0, k[0] && m == 0, d});
			end
			v = m[1] ? 32'hc : 32'h0;
			chk({27'h0, port_out_data_valid_oe_n, port_out_data_bus_oe_n}, v);
			// MII PHY side passes the idle request on as a plain word
			v = 32'(seen_cnt) + ((m == 1) ? 32'h1 : 32'h0);
			send(4'h0, 1'b0, 1'b1);
			chk(32'(seen_cnt), v);
			if (m == 0) chk({28'h0, idle_nib}, {28'h0, LPI_NIBBLE});
			chk({31'h0, port_out_error}, 32'h0);
			for (int k = 0; k < 6; k++) begin
				ctl = (32'($urandom) & 32'h0000_2100) | (32'(k[0]) << BIT_AUTONEG);
				wr(ADDR_BASIC_CTRL, ctl, RESP_OKAY);
				rd(ADDR_BASIC_CTRL, v, RESP_OKAY);
				chk(v, ctl);
				port_speed_indication_in <= 1'($urandom);
				port_duplex_indication_in <= 1'($urandom);
				repeat (8) @(posedge aclk);
				chk({30'h0, link_speed, link_duplex}, {30'h0, exp_link(m[0], ctl)});
			end
			wr(ADDR_BASIC_CTRL, BASIC_CTRL_RESET | 32'h0000_0400, RESP_OKAY);
			repeat (24) @(posedge aclk);
			v = m[0] ? 32'h1f : (m[1] ? 32'hc : 32'h0);
			chk({27'h0, port_out_data_valid_oe_n, port_out_data_bus_oe_n}, v);
			wr(ADDR_BASIC_CTRL, BASIC_CTRL_RESET, RESP_OKAY);
			if (m == 2) begin
				port_mode_strap_bit1 <= 1'b1;
				wr(ADDR_STATUS, 32'h0000_00ff, RESP_OKAY);
				rd(ADDR_STATUS, v, RESP_OKAY);
				chk(v & 32'h3, 32'h2);
				wr(ADDR_SPECIAL_CTRL, 32'hffff_ffff, RESP_OKAY);
				rd(ADDR_SPECIAL_CTRL, v, RESP_OKAY);
				chk(v, 32'h1);
				chk({31'h0, ref_clock_drive}, 32'h1);
			end
		end
		conclude();
	end
endmodule : port_out_side_bench
